// File: design/cltv_pkg.sv
package cltv_pkg;
    // system clock and analog link rate
    localparam int CLK_MHZ       = 8;
    localparam int LINK_KHZ      = 500;
    localparam int QTR_CYC       = (CLK_MHZ * 1000) / (4 * LINK_KHZ);
    // analog section link target and register map
    localparam logic [6:0] ANA_ADDR    = 7'h40;
    localparam logic [7:0] REG_ADC_LO  = 8'h07;
    localparam logic [7:0] REG_ADC_HI  = 8'h08;
    localparam logic [7:0] REG_ADC_MUX = 8'h09;
    localparam logic [7:0] REG_DAC1    = 8'h13;
    localparam int         MUX_ADC_RANGE_SELECT   = 4;
    // trim values
    localparam int         MEAS_W      = 12;
    localparam int         TGT_W       = 13;
    localparam int         ADC_RANGE_SELECT_BIT   = 12;
    localparam logic [7:0] DAC_MAX     = 8'hFF;
    localparam logic [7:0] DAC_MIN     = 8'h00;
    localparam logic [7:0] DAC_STEP    = 8'h01;
    localparam int         VID_N       = 16;
    localparam int         VID_W       = 4;
    // link byte framing
    localparam logic [3:0] BIT_ACK     = 4'h8;
    localparam logic [1:0] STEP_ADDR   = 2'h0;
    localparam logic [1:0] STEP_REG    = 2'h1;
    localparam logic [1:0] STEP_DATA   = 2'h2;
    localparam logic [1:0] STEP_READ   = 2'h3;
    localparam logic [1:0] Q0          = 2'h0;
    localparam logic [1:0] Q1          = 2'h1;
    localparam logic [1:0] Q2          = 2'h2;
    localparam logic [1:0] Q3          = 2'h3;

    typedef enum logic [2:0] {S_SCAN, S_MUX, S_RDHI, S_RDLO, S_CALC, S_DAC} cltv_state_t;
    typedef enum logic [1:0] {L_IDLE, L_START, L_BIT, L_STOP} cltv_link_t;
endpackage

// File: design/cltv_link.sv
`timescale 1ns/1ps
`default_nettype none
module cltv_link
    import cltv_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    input  wire logic       i_start,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_reg,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_busy,
    output logic            o_done,
    output logic            o_nack,
    output logic [7:0]      o_rdata,
    output logic            o_scl,
    output logic            o_scl_oe,
    output logic            o_sda,
    output logic            o_sda_oe
);
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [7:0] cnt;
    logic       tick;
    cltv_link_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] step;
    logic       rd;
    logic [7:0] rg;
    logic [7:0] wd;
    logic [7:0] sh;
    logic [7:0] rx;

    function automatic logic [7:0] byte_of(input logic [1:0] s);
        logic [7:0] b;
        b = DAC_MAX;
        if (s == STEP_ADDR) begin
            b = {ANA_ADDR, 1'b0};
        end else if (s == STEP_REG) begin
            b = rg;
        end else if (s == STEP_DATA) begin
            b = rd ? {ANA_ADDR, 1'b1} : wd;
        end
        return b;
    endfunction

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_sy <= 2'h0;
            sda_sy <= 2'h0;
        end else if (i_ce) begin
            scl_sy <= {scl_sy[0], i_scl};
            sda_sy <= {sda_sy[0], i_sda};
        end
    end

    assign tick = (cnt == 8'(QTR - 1));

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 8'h00;
        end else if (i_ce) begin
            cnt <= (tick || st == L_IDLE) ? 8'h00 : cnt + 8'h01;
        end
    end

    // open-drain: pin output is always low, the enable pulls the wire
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_scl <= 1'b0;
            o_sda <= 1'b0;
        end else begin
            o_scl <= 1'b0;
            o_sda <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= L_IDLE;
            q <= Q0;
            bitn <= 4'h0;
            step <= STEP_ADDR;
            rd <= 1'b0;
            rg <= 8'h00;
            wd <= 8'h00;
            sh <= 8'h00;
            rx <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_rdata <= 8'h00;
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (st == L_IDLE) begin
                if (i_start) begin
                    st <= L_START;
                    q <= Q0;
                    step <= STEP_ADDR;
                    rd <= i_rd;
                    rg <= i_reg;
                    wd <= i_wdata;
                    o_nack <= 1'b0;
                    o_busy <= 1'b1;
                end
            end else if (tick) begin
                q <= q + 2'h1;
                case (st)
                    L_START: begin
                        if (q == Q0) begin
                            o_sda_oe <= 1'b0;
                            o_scl_oe <= 1'b0;
                        end else if (q == Q1) begin
                            o_sda_oe <= 1'b1;
                        end else if (q == Q2) begin
                            o_scl_oe <= 1'b1;
                            st <= L_BIT;
                            q <= Q0;
                            bitn <= 4'h0;
                            sh <= byte_of(step);
                        end
                    end
                    L_BIT: begin
                        if (q == Q0) begin
                            o_sda_oe <= (bitn != BIT_ACK) && (step != STEP_READ) && !sh[7];
                        end else if (q == Q1) begin
                            o_scl_oe <= 1'b0;
                        end else if (q == Q2) begin
                            if (!scl_sy[1]) begin
                                q <= Q2;
                            end else if (bitn == BIT_ACK) begin
                                if (step != STEP_READ && sda_sy[1]) begin
                                    o_nack <= 1'b1;
                                end
                            end else begin
                                rx <= {rx[6:0], sda_sy[1]};
                                sh <= {sh[6:0], 1'b0};
                            end
                        end else begin
                            o_scl_oe <= 1'b1;
                            if (bitn != BIT_ACK) begin
                                bitn <= bitn + 4'h1;
                            end else if (step == STEP_READ || (step == STEP_DATA && !rd)) begin
                                st <= L_STOP;
                            end else if (step == STEP_REG && rd) begin
                                st <= L_START;
                                step <= STEP_DATA;
                            end else begin
                                step <= step + 2'h1;
                                sh <= byte_of(step + 2'h1);
                                bitn <= 4'h0;
                            end
                        end
                    end
                    L_STOP: begin
                        if (q == Q0) begin
                            o_sda_oe <= 1'b1;
                        end else if (q == Q1) begin
                            o_scl_oe <= 1'b0;
                        end else if (q == Q2) begin
                            o_sda_oe <= 1'b0;
                        end else begin
                            st <= L_IDLE;
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                            o_rdata <= rx;
                        end
                    end
                    default: st <= L_IDLE;
                endcase
            end
        end
    end

    sequence stop_edge_s;
        st == L_STOP && q == Q2 && tick && i_ce;
    endsequence

    sda_scl_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st == L_BIT && $changed(o_sda_oe)) |-> o_scl_oe)
        else $error("link data moved while clock high");
    stop_done_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        stop_edge_s |=> !o_sda_oe && !o_scl_oe)
        else $error("stop condition not released");
endmodule
`default_nettype wire

// File: design/cltv_trim.sv
// How it works
// - one system clock, global asynchronous reset active low
// - channel count is a parameter, up to eight independent loops
// - channel n measures monitor n and drives trim DAC n only
// - ADC reads and DAC writes go out as master on analog link
// - positive loop: measurement below target raises DAC count
// - positive loop: above target lowers count; repeats until equal
// - sixteen-entry VID table indexed by four-bit pin code
// - at most two VID channels, each four code pins and low enable
// - both VID channels read one shared table
// - enable falling loads table entry as target and sets enable bit
// - trimming continues after VID enable returns high
// - only a host enable write stops VID-started trimming
// - new falling enable with new code loads new target
// - VID use needs host writes to fill the table first; reset clears every entry to zero
// - one DAC step per link round, so slewing is slow
// - polarity bit one reverses both step directions
// - cleared enable halts channel, DAC holds last value
// - target is 12-bit ADC code plus range select bit
`timescale 1ns/1ps
`default_nettype none
module cltv_trim
    import cltv_pkg::*;
#(
    parameter int NCH      = 8,
    parameter int NVID     = 2,
    parameter int VID_A_CH = 0,
    parameter int VID_B_CH = 1
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_ce,
    input  wire logic                 i_en_wr,
    input  wire logic [NCH-1:0]       i_en_data,
    input  wire logic [NCH-1:0]       i_pol,
    input  wire logic                 i_tgt_wr,
    input  wire logic [2:0]           i_tgt_chan,
    input  wire logic [TGT_W-1:0]     i_tgt_data,
    input  wire logic                 i_dac_wr,
    input  wire logic [2:0]           i_dac_chan,
    input  wire logic [7:0]           i_dac_data,
    input  wire logic                 i_vid_wr,
    input  wire logic [VID_W-1:0]     i_vid_idx,
    input  wire logic [TGT_W-1:0]     i_vid_data,
    input  wire logic [VID_W-1:0]     i_vid_a_code,
    input  wire logic                 i_vid_a_activate_n,
    input  wire logic [VID_W-1:0]     i_vid_b_code,
    input  wire logic                 i_vid_b_activate_n,
    input  wire logic                 i_link_clock,
    input  wire logic                 i_link_data,
    output logic                      o_link_clock,
    output logic                      o_link_clock_oe,
    output logic                      o_link_data,
    output logic                      o_link_data_oe,
    output logic                      o_link_nack,
    output logic [NCH-1:0]            o_chan_enable,
    output logic [NCH-1:0][7:0]       o_dac
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    logic [NCH-1:0]            en;
    logic [NCH-1:0][TGT_W-1:0] tgt;
    logic [NCH-1:0][7:0]       dac;
    logic [TGT_W-1:0]          vid_tbl [VID_N];
    logic [1:0][VID_W:0]       vid_in;
    logic [1:0][VID_W:0]       vid_s1;
    logic [1:0][VID_W:0]       vid_s2;
    logic [1:0]                vid_prev;
    logic [1:0]                vid_fall;
    cltv_state_t               st;
    logic [2:0]                cur;
    logic [7:0]                adc_hi;
    logic [MEAS_W-1:0]         meas;
    logic [7:0]                next_dac;
    logic [7:0]                cur_dac;
    logic [TGT_W-1:0]          cur_tgt;
    logic                      step_up;
    logic                      step_dn;
    logic                      pend;
    logic                      lk_start;
    logic                      lk_rd;
    logic [7:0]                lk_reg;
    logic [7:0]                lk_wd;
    logic                      lk_busy;
    logic                      lk_done;
    logic [7:0]                lk_rdata;

    assign vid_in[0] = {i_vid_a_activate_n, i_vid_a_code};
    assign vid_in[1] = {i_vid_b_activate_n, i_vid_b_code};
    assign o_chan_enable = en;
    assign o_dac = dac;
    assign cur_dac = dac[cur];
    assign cur_tgt = tgt[cur];

    // VID pins are asynchronous: two flops before the edge detector
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            vid_s1 <= '1;
            vid_s2 <= '1;
            vid_prev <= 2'h3;
        end else if (i_ce) begin
            vid_s1 <= vid_in;
            vid_s2 <= vid_s1;
            vid_prev <= {vid_s2[1][VID_W], vid_s2[0][VID_W]};
        end
    end

    generate
        for (genvar v = 0; v < 2; v++) begin : g_vid
            localparam int CH = (v == 0) ? VID_A_CH : VID_B_CH;
            logic [TGT_W-1:0] pick;
            assign vid_fall[v] = (v < NVID) && vid_prev[v] && !vid_s2[v][VID_W];
            assign pick = vid_tbl[vid_s2[v][VID_W-1:0]];
            if (v < NVID) begin : g_chk
                vid_load_a: assert property (vid_fall[v] && i_ce
                    |=> en[CH] && tgt[CH] == $past(pick))
                    else $error("VID activation did not load target and enable");
                vid_keep_a: assert property (i_ce && en[CH] && !i_en_wr
                    |=> en[CH])
                    else $error("VID-started trimming stopped without host write");
            end
        end
    endgenerate

    // shared VID table, filled by the host before use
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < VID_N; k++) begin
                vid_tbl[k] <= '0;
            end
        end else if (i_ce && i_vid_wr) begin
            vid_tbl[i_vid_idx] <= i_vid_data;
        end
    end

    // targets and enables: a VID load in the same cycle beats the host
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tgt <= '0;
            en <= '0;
        end else if (i_ce) begin
            if (i_tgt_wr && 32'(i_tgt_chan) < NCH) begin
                tgt[i_tgt_chan] <= i_tgt_data;
            end
            if (i_en_wr) begin
                en <= i_en_data;
            end
            for (int v = 0; v < 2; v++) begin
                if (vid_fall[v]) begin
                    tgt[(v == 0) ? VID_A_CH : VID_B_CH] <= g_vid[0].pick;
                    en[(v == 0) ? VID_A_CH : VID_B_CH] <= 1'b1;
                end
            end
            if (vid_fall[1]) begin
                tgt[VID_B_CH] <= g_vid[1].pick;
            end
        end
    end

    assign meas = {adc_hi[3:0], lk_rdata};
    always_comb begin
        step_up = i_pol[cur] ? (meas > cur_tgt[MEAS_W-1:0]) : (meas < cur_tgt[MEAS_W-1:0]);
        step_dn = i_pol[cur] ? (meas < cur_tgt[MEAS_W-1:0]) : (meas > cur_tgt[MEAS_W-1:0]);
        next_dac = cur_dac;
        if (step_up && cur_dac != DAC_MAX) begin
            next_dac = cur_dac + DAC_STEP;
        end else if (step_dn && cur_dac != DAC_MIN) begin
            next_dac = cur_dac - DAC_STEP;
        end
    end

    // request that the present state puts on the link
    always_comb begin
        lk_rd = 1'b0;
        lk_reg = REG_ADC_MUX;
        lk_wd = 8'h00;
        lk_wd[MUX_ADC_RANGE_SELECT] = cur_tgt[ADC_RANGE_SELECT_BIT];
        lk_wd[2:0] = cur;
        if (st == S_RDHI) begin
            lk_rd = 1'b1;
            lk_reg = REG_ADC_HI;
        end else if (st == S_RDLO) begin
            lk_rd = 1'b1;
            lk_reg = REG_ADC_LO;
        end else if (st == S_DAC) begin
            lk_reg = REG_DAC1 + 8'(cur);
            lk_wd = cur_dac;
        end
    end

    // round robin over enabled channels, one step per visit
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= S_SCAN;
            cur <= 3'h0;
            pend <= 1'b0;
            lk_start <= 1'b0;
            adc_hi <= 8'h00;
        end else if (i_ce) begin
            lk_start <= 1'b0;
            case (st)
                S_SCAN: begin
                    if (en[cur]) begin
                        st <= S_MUX;
                    end else begin
                        cur <= (32'(cur) == NCH - 1) ? 3'h0 : cur + 3'h1;
                    end
                end
                S_CALC: begin
                    if (en[cur] && next_dac != cur_dac) begin
                        st <= S_DAC;
                    end else begin
                        st <= S_SCAN;
                        cur <= (32'(cur) == NCH - 1) ? 3'h0 : cur + 3'h1;
                    end
                end
                default: begin
                    if (!pend && !lk_busy) begin
                        lk_start <= 1'b1;
                        pend <= 1'b1;
                    end else if (lk_done) begin
                        pend <= 1'b0;
                        if (st == S_MUX) begin
                            st <= S_RDHI;
                        end else if (st == S_RDHI) begin
                            adc_hi <= lk_rdata;
                            st <= S_RDLO;
                        end else if (st == S_RDLO) begin
                            st <= S_CALC;
                        end else begin
                            st <= S_SCAN;
                            cur <= (32'(cur) == NCH - 1) ? 3'h0 : cur + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dac <= '0;
        end else if (i_ce) begin
            if (st == S_CALC && en[cur]) begin
                dac[cur] <= next_dac;
            end else if (i_dac_wr && 32'(i_dac_chan) < NCH) begin
                dac[i_dac_chan] <= i_dac_data;
            end
        end
    end

    cltv_link u_link (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_ce     (i_ce),
        .i_start  (lk_start),
        .i_rd     (lk_rd),
        .i_reg    (lk_reg),
        .i_wdata  (lk_wd),
        .i_scl    (i_link_clock),
        .i_sda    (i_link_data),
        .o_busy   (lk_busy),
        .o_done   (lk_done),
        .o_nack   (o_link_nack),
        .o_rdata  (lk_rdata),
        .o_scl    (o_link_clock),
        .o_scl_oe (o_link_clock_oe),
        .o_sda    (o_link_data),
        .o_sda_oe (o_link_data_oe)
    );

    sequence calc_s;
        st == S_CALC && i_ce && en[cur];
    endsequence

    link_idle_a: assert property (lk_start |-> !lk_busy)
        else $error("link request while link busy");
    mux_index_a: assert property (lk_start && st == S_MUX |-> lk_wd[2:0] == cur)
        else $error("monitor select does not match channel");
    step_up_a: assert property (calc_s ##0 (step_up && cur_dac != DAC_MAX)
        |=> cur_dac == $past(cur_dac) + DAC_STEP && st == S_DAC)
        else $error("DAC count did not rise by one");
    step_dn_a: assert property (calc_s ##0 (step_dn && cur_dac != DAC_MIN)
        |=> cur_dac == $past(cur_dac) - DAC_STEP && st == S_DAC)
        else $error("DAC count did not fall by one");
    equal_hold_a: assert property (calc_s ##0 (meas == cur_tgt[MEAS_W-1:0])
        |=> dac[$past(cur)] == $past(cur_dac) && st == S_SCAN)
        else $error("DAC changed at target");
    dac_hold_a: assert property (!(|en) && !i_dac_wr |=> $stable(dac))
        else $error("DAC moved while all channels disabled");
endmodule
`default_nettype wire

// File: testbench/cltv_ana_model.sv
`timescale 1ns/1ps
`default_nettype none
module cltv_ana_model
    import cltv_pkg::*;
(
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic [11:0] i_meas,
    output logic             o_sda_oe,
    output logic [7:0]       o_dac1,
    output int               o_stops
);
    logic [7:0] sh, ptr, tx;
    logic       rd;
    int         nb, nbyte;
    initial begin
        {o_sda_oe, o_dac1, sh, ptr, tx, rd} = '0;
        {o_stops, nb, nbyte} = '0;
    end
    // start condition restarts byte framing, pointer survives for reads
    always @(negedge i_sda) begin
        if (i_scl) begin
            nb = 0;
            nbyte = 0;
            rd = 1'b0;
        end
    end
    always @(posedge i_sda) begin
        if (i_scl) begin
            o_stops = o_stops + 1;
        end
    end
    always @(posedge i_scl) begin
        sh = {sh[6:0], i_sda};
        nb = nb + 1;
    end
    // ack written bytes, serve one byte from the pointed adc register
    always @(negedge i_scl) begin
        if (nb == 8) begin
            if (nbyte == 0) rd = sh[0];
            else if (!rd && nbyte == 1) ptr = sh;
            else if (!rd && ptr == REG_DAC1) o_dac1 = sh;
            o_sda_oe = !(rd && nbyte == 1) && (nbyte > 0 || sh[7:1] == ANA_ADDR);
        end else if (nb == 9) begin
            nb = 0;
            nbyte = nbyte + 1;
            tx = (ptr == REG_ADC_HI) ? {4'h0, i_meas[11:8]} : i_meas[7:0];
            o_sda_oe = rd && nbyte == 1 && !tx[7];
        end else if (rd && nbyte == 1) begin
            o_sda_oe = !tx[7 - nb];
        end
    end
endmodule
`default_nettype wire

// File: testbench/cltv_trim_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cltv_trim_tb_top import cltv_pkg::*; ();
    logic            i_clk, i_nrst, en_wr, tgt_wr, dac_wr, vid_wr, va_n, vb_n, ce;
    logic            scl_oe, sda_oe, p_oe;
    logic [7:0]      en_data, pol, dac_data, chen, p_dac1;
    logic [12:0]     tgt_data, vid_data;
    logic [3:0]      vid_idx, va_code, vb_code;
    logic [11:0]     meas;
    logic [7:0][7:0] dac;
    wire logic       scl_w, sda_w;
    int              failures, n_compared, p_stops;
    assign scl_w = !scl_oe;
    assign sda_w = !(sda_oe || p_oe);
    always #5 i_clk = !i_clk;
    cltv_trim DUT (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_en_wr(en_wr), .i_en_data(en_data),
        .i_pol(pol), .i_tgt_wr(tgt_wr), .i_tgt_chan(3'h0), .i_tgt_data(tgt_data),
        .i_dac_wr(dac_wr), .i_dac_chan(3'h0), .i_dac_data(dac_data), .i_vid_wr(vid_wr),
        .i_vid_idx(vid_idx), .i_vid_data(vid_data), .i_vid_a_code(va_code),
        .i_vid_a_activate_n(va_n), .i_vid_b_code(vb_code), .i_vid_b_activate_n(vb_n),
        .i_link_clock(scl_w), .i_link_data(sda_w), .o_link_clock(), .o_link_clock_oe(scl_oe),
        .o_link_data(), .o_link_data_oe(sda_oe), .o_link_nack(), .o_chan_enable(chen),
        .o_dac(dac));
    cltv_ana_model PARTNER (.i_scl(scl_w), .i_sda(sda_w), .i_meas(meas), .o_sda_oe(p_oe),
        .o_dac1(p_dac1), .o_stops(p_stops));
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one-cycle host strobe: 0 enable, 1 target, 2 dac preset, 3 table
    task automatic strobe(input int k);
        @(negedge i_clk);
        {vid_wr, dac_wr, tgt_wr, en_wr} = 4'h1 << k;
        @(negedge i_clk);
        {vid_wr, dac_wr, tgt_wr, en_wr} = 4'h0;
    endtask
    // waits while: 0 dac unchanged, 1 link dac differs, 2 too few stops
    task automatic wait_for(input int k, input int v);
        int n;
        n = 0;
        while (n < 5000 && (k == 0 ? dac[0] == v : (k == 1 ? p_dac1 != v : p_stops < v))) begin
            @(negedge i_clk);
            n++;
        end
        repeat (40) @(negedge i_clk);
        check("wait", n < 5000, 1'b1);
    endtask
    task automatic t_reset;
        check("chan enable", chen, 8'h00);
        check("dac count", dac[0], 8'h00);
        check("link drive", {scl_oe, sda_oe}, 2'h0);
    endtask
    task automatic t_host_loop;
        dac_data = 8'h80;
        strobe(2);
        tgt_data = 13'h0100;
        strobe(1);
        en_data = 8'h01;
        strobe(0);
        check("chan enable", chen, 8'h01);
        wait_for(0, 8'h80);
        check("step up", dac[0], 8'h81);
        check("other dac", dac[1], 8'h00);
        en_data = 8'h00;
        strobe(0);
        wait_for(1, 8'h81);
        check("link dac", p_dac1, 8'h81);
        repeat (2000) @(negedge i_clk);
        check("hold dac", dac[0], 8'h81);
        check("halted", chen, 8'h00);
    endtask
    task automatic t_vid;
        int s;
        vid_idx = 4'h5;
        vid_data = 13'h0080;
        strobe(3);
        vid_idx = 4'h6;
        vid_data = 13'h1000;
        strobe(3);
        va_code = 4'h5;
        @(negedge i_clk);
        va_n = 1'b0;
        repeat (4) @(negedge i_clk);
        check("vid enable", chen, 8'h01);
        va_n = 1'b1;
        s = p_stops;
        wait_for(2, s + 3);
        check("equal hold", dac[0], 8'h81);
        check("stays on", chen[0], 1'b1);
        pol = 8'h01;
        va_code = 4'h6;
        vb_code = 4'h6;
        repeat (4) @(negedge i_clk);
        va_n = 1'b0;
        wait_for(0, 8'h81);
        check("reversed step", dac[0], 8'h82);
        vb_n = 1'b0;
        repeat (5) @(negedge i_clk);
        check("vid b enable", chen, 8'h03);
        pol = 8'h00;
        wait_for(0, 8'h82);
        check("step down", dac[0], 8'h81);
        ce = 1'b0;
        en_data = 8'h00;
        strobe(0);
        check("frozen enable", chen, 8'h03);
        ce = 1'b1;
        strobe(0);
        check("host stop", chen, 8'h00);
    endtask
    initial begin
        {i_clk, i_nrst, en_wr, tgt_wr, dac_wr, vid_wr, en_data, pol, dac_data} = '0;
        {tgt_data, vid_data, vid_idx, va_code, vb_code} = '0;
        {va_n, vb_n, ce} = 3'h7;
        meas = 12'h080;
        failures = 0;
        n_compared = 0;
        repeat (12) @(negedge i_clk);
        t_reset();
        i_nrst = 1'b1;
        t_host_loop();
        t_vid();
        complete_run();
    end
    initial begin
        #400000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
